// >>> hw/shadow_pkg.sv
/*
  Package for the runtime shadow and function disable register group:
  offsets, field positions, reset values, bus timing and carrier structs.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package shadow_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_FLOPPY_RATE   = 8'h1f;
  localparam logic [7:0]  IDX_SERIAL_ONE    = 8'h20;
  localparam logic [7:0]  IDX_SERIAL_TWO    = 8'h21;
  localparam logic [7:0]  IDX_FUNC_DISABLE  = 8'h22;
  localparam int          ADDR_W            = 10;

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int          DIS_WP_BIT        = 0;
  localparam int          DIS_FLOPPY_BIT    = 3;
  localparam int          DIS_MIDI_BIT      = 4;
  localparam int          DIS_SER_TWO_BIT   = 5;
  localparam int          DIS_SER_ONE_BIT   = 6;
  localparam int          DIS_PARALLEL_BIT  = 7;
  localparam logic [7:0]  DIS_WRITABLE_MASK = 8'hf9;
  localparam logic [7:0]  DIS_RESET         = 8'h00;
  localparam logic [1:0]  LOCK_CFG_LOCKING  = 2'h1;
  localparam logic [31:0] RDATA_UNMAPPED    = 32'h0000_0000;
  localparam int          WAIT_CYCLES       = 0;

  // ---------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       soft_reset;
    logic       power_down;
    logic [2:0] precompensation_select;
    logic [1:0] data_rate_select;
  } floppy_rate_type;

  typedef struct packed {
    logic [1:0] rx_trigger;
    logic       dma_mode;
    logic       tx_fifo_reset;
    logic       rx_fifo_reset;
    logic       fifo_enable;
  } fifo_ctrl_type;

  typedef struct packed {
    logic parallel;
    logic serial_port_one;
    logic serial_port_two;
    logic midi;
    logic floppy;
  } func_set_type;

  function automatic logic [7:0] pack_rate(input floppy_rate_type r);
    pack_rate = {r.soft_reset, r.power_down, 1'b0, r.precompensation_select,
                 r.data_rate_select};
  endfunction : pack_rate

  function automatic logic [7:0] pack_fifo(input fifo_ctrl_type f);
    pack_fifo = {f.rx_trigger, 2'b00, f.dma_mode, f.tx_fifo_reset, f.rx_fifo_reset,
                 f.fifo_enable};
  endfunction : pack_fifo

endpackage : shadow_pkg

// >>> hw/write_protect_merge.sv
/*
  Merge of the write protect sources seen by the floppy controller core.
  Assumes active-low drive selects and write protect from the drive cable.
*/
`timescale 1ns/1ps
module write_protect_merge
  import shadow_pkg::*;
(
  input  wire logic drive_select_zero_n,    // drive 0 select, active low
  input  wire logic drive_select_one_n,     // drive 1 select, active low
  input  wire logic force_write_protect,    // forced protect configuration bit
  input  wire logic write_protect_n,        // protect from drive, active low
  input  wire logic reg_write_protect,      // register protect bit
  output logic      core_write_protect      // protect seen by core, active high
);

  // ---------------------------------------------------------------
  // four-term or
  // ---------------------------------------------------------------
  wire sel0_forced = !drive_select_zero_n && force_write_protect;
  wire sel1_forced = !drive_select_one_n && force_write_protect;

  assign core_write_protect = sel0_forced || sel1_forced || !write_protect_n
                              || reg_write_protect;

endmodule : write_protect_merge

// >>> hw/runtime_shadow_disable.sv
/*
  APB register group: three read-only shadows of write-only control
  settings and a lockable function disable register that gates the
  activate bits and forces floppy write protection.
  Assumes inputs synchronous to pclk and a standby-supply reset on presetn.
*/
`timescale 1ns/1ps
module runtime_shadow_disable
  import shadow_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W           // apb address width
)(
  input  wire logic                  pclk,            // apb clock, 250 MHz
  input  wire logic                  presetn,         // async reset, active low
  input  wire logic                  psel,            // apb select
  input  wire logic                  penable,         // apb access phase
  input  wire logic                  pwrite,          // apb direction
  input  wire logic [ADDR_WIDTH-1:0] paddr,           // apb byte address
  input  wire logic [31:0]           pwdata,          // apb write data
  input  wire logic [3:0]            pstrb,           // apb byte strobes
  output logic [31:0]                prdata,          // apb read data
  output logic                       pready,          // apb ready
  output logic                       pslverr,         // apb error
  input  wire floppy_rate_type       floppy_rate,     // floppy rate setting
  input  wire fifo_ctrl_type         serial_one_fifo, // port one fifo setting
  input  wire fifo_ctrl_type         serial_two_fifo, // port two fifo setting
  input  wire logic [1:0]            lock_cfg,        // lock pin config bits 3:2
  input  wire logic                  lock_pin,        // lock pin level
  input  wire func_set_type          activate,        // per-function activate bits
  input  wire logic                  drive_select_zero_n, // drive 0 select
  input  wire logic                  drive_select_one_n,  // drive 1 select
  input  wire logic                  write_protect_n,     // drive protect input
  input  wire logic                  force_write_protect, // forced protect bit
  output func_set_type               enabled,         // effective enables
  output logic                       core_write_protect   // protect to core
);

  // elaboration check: the highest register byte address must fit
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_width
    $error("address width must hold offset 0x88");
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_WIDTH'({idx, 2'b00}));
  endfunction : hit

  wire hit_rate  = hit(paddr, IDX_FLOPPY_RATE);
  wire hit_one   = hit(paddr, IDX_SERIAL_ONE);
  wire hit_two   = hit(paddr, IDX_SERIAL_TWO);
  wire hit_dis   = hit(paddr, IDX_FUNC_DISABLE);
  wire mapped    = hit_rate || hit_one || hit_two || hit_dis;
  wire access    = psel && penable;
  wire locked    = (lock_cfg == LOCK_CFG_LOCKING) && lock_pin;
  wire dis_write = access && pwrite && hit_dis && pstrb[0] && !locked;

  // ---------------------------------------------------------------
  // function disable register
  // ---------------------------------------------------------------
  logic [7:0] disable_q;
  logic [7:0] disable_d;

  assign disable_d = dis_write ? (pwdata[7:0] & DIS_WRITABLE_MASK) : disable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disable_q <= DIS_RESET;
    end else begin
      disable_q <= disable_d;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  assign rdata_d = hit_rate ? {24'h000000, pack_rate(floppy_rate)}
                 : hit_one  ? {24'h000000, pack_fifo(serial_one_fifo)}
                 : hit_two  ? {24'h000000, pack_fifo(serial_two_fifo)}
                 : hit_dis  ? {24'h000000, disable_q}
                 : RDATA_UNMAPPED;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && !hit_dis));

  // ---------------------------------------------------------------
  // function gating
  // ---------------------------------------------------------------
  assign enabled.floppy          = activate.floppy && !disable_q[DIS_FLOPPY_BIT];
  assign enabled.midi            = activate.midi && !disable_q[DIS_MIDI_BIT];
  assign enabled.serial_port_two = activate.serial_port_two
                                   && !disable_q[DIS_SER_TWO_BIT];
  assign enabled.serial_port_one = activate.serial_port_one
                                   && !disable_q[DIS_SER_ONE_BIT];
  assign enabled.parallel        = activate.parallel && !disable_q[DIS_PARALLEL_BIT];

  write_protect_merge u_wp (
    .drive_select_zero_n (drive_select_zero_n),
    .drive_select_one_n  (drive_select_one_n),
    .force_write_protect (force_write_protect),
    .write_protect_n     (write_protect_n),
    .reg_write_protect   (disable_q[DIS_WP_BIT]),
    .core_write_protect  (core_write_protect)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lock_holds_reg: assert property (access && pwrite && hit_dis && locked
      |=> disable_q == $past(disable_q)) else $error("locked write changed register");
  a_write_lands: assert property (access && pwrite && hit_dis && pstrb[0] && !locked
      |=> disable_q == ($past(pwdata[7:0]) & 8'hf9)) else $error("write not stored");
  a_reserved_zero: assert property (disable_q[2:1] == 2'b00)
      else $error("reserved disable bits set");
  a_rate_shadow: assert property (psel && !penable && !pwrite && hit_rate
      |=> prdata[7:0] == pack_rate($past(floppy_rate)) && prdata[5] == 1'b0)
      else $error("rate shadow mismatch");
  a_one_shadow: assert property (psel && !penable && !pwrite && hit_one
      |=> prdata[7:0] == pack_fifo($past(serial_one_fifo)) && prdata[5:4] == 2'b00)
      else $error("serial one shadow mismatch");
  a_two_shadow: assert property (psel && !penable && !pwrite && hit_two
      |=> prdata[7:0] == pack_fifo($past(serial_two_fifo)))
      else $error("serial two shadow mismatch");
  a_floppy_gate: assert property (disable_q[3] |-> !enabled.floppy)
      else $error("floppy not disabled");
  a_midi_gate: assert property (!disable_q[4] |-> enabled.midi == activate.midi)
      else $error("midi gating wrong");
  a_ser_two_gate: assert property (disable_q[5] |-> !enabled.serial_port_two)
      else $error("serial two not disabled");
  a_ser_one_gate: assert property (!disable_q[6]
      |-> enabled.serial_port_one == activate.serial_port_one)
      else $error("serial one gating wrong");
  a_par_gate: assert property (disable_q[7] |-> !enabled.parallel)
      else $error("parallel not disabled");
  a_wp_forced: assert property (disable_q[0] |-> core_write_protect)
      else $error("register protect not forced");
  a_wp_merge: assert property (core_write_protect == ((!drive_select_zero_n
      && force_write_protect) || (!drive_select_one_n && force_write_protect)
      || !write_protect_n || disable_q[0])) else $error("protect merge wrong");

  c_locked_write: cover property (access && pwrite && hit_dis && locked);
  c_open_write:   cover property (access && pwrite && hit_dis && !locked);
  c_read_rate:    cover property (access && !pwrite && hit_rate);
  c_all_disabled: cover property (disable_q == 8'hf9);

endmodule : runtime_shadow_disable

// >>> dv/testbench.sv
/*
  Self-checking bench for the runtime shadow and function disable group.
  Assumes the shadow_pkg package and the runtime_shadow_disable module.
*/
`timescale 1ns/1ps
module testbench;
  import shadow_pkg::*;
  // ---------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------
  logic            pclk, presetn, psel, penable, pwrite;
  logic [9:0]      paddr;
  logic [31:0]     pwdata, prdata;
  logic [3:0]      pstrb;
  logic            pready, pslverr, lock_pin, core_write_protect;
  logic [1:0]      lock_cfg;
  logic            drive_select_zero_n, drive_select_one_n, write_protect_n, force_write_protect;
  floppy_rate_type floppy_rate;
  fifo_ctrl_type   serial_one_fifo, serial_two_fifo;
  func_set_type    activate, enabled;
  int              n_mismatch, total_checks;
  logic [31:0]     rd;
  logic            err;
  runtime_shadow_disable #(.ADDR_WIDTH(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .floppy_rate(floppy_rate),
    .serial_one_fifo(serial_one_fifo), .serial_two_fifo(serial_two_fifo), .lock_cfg(lock_cfg),
    .lock_pin(lock_pin), .activate(activate), .drive_select_zero_n(drive_select_zero_n),
    .drive_select_one_n(drive_select_one_n), .write_protect_n(write_protect_n),
    .force_write_protect(force_write_protect), .enabled(enabled),
    .core_write_protect(core_write_protect));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_en(input logic [7:0] dis);
    @(negedge pclk);
    chk({27'h0, enabled}, {27'h0, activate & ~dis[7:3]});
    @(posedge pclk);
  endtask : chk_en
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, 10'h088, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, pready}, 32'h1);
    chk_en(8'h00);
    apb(1'b0, 10'h08c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_shadow;
    floppy_rate <= 7'b1011001;
    serial_one_fifo <= 6'b101010;
    serial_two_fifo <= 6'b010101;
    apb(1'b0, 10'h07c, 32'h0);
    chk(rd, 32'h99);
    apb(1'b0, 10'h080, 32'h0);
    chk(rd, 32'h8a);
    apb(1'b0, 10'h084, 32'h0);
    chk(rd, 32'h45);
    floppy_rate <= 7'h7f;
    serial_one_fifo <= 6'h3f;
    serial_two_fifo <= 6'h3f;
    apb(1'b1, 10'h07c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 10'h07c, 32'h0);
    chk(rd, 32'hdf);
    apb(1'b0, 10'h080, 32'h0);
    chk(rd, 32'hcf);
    apb(1'b0, 10'h084, 32'h0);
    chk(rd, 32'hcf);
    $display("test shadow done");
  endtask : t_shadow
  task automatic t_disable;
    logic [7:0] d;
    for (int k = 0; k < 6; k++) begin
      d = (k < 5) ? (8'h08 << k) : 8'hff;
      activate <= 5'h1f;
      apb(1'b1, 10'h088, {24'hffffff, d});
      chk({31'h0, err}, 32'h0);
      apb(1'b0, 10'h088, 32'h0);
      chk(rd, {24'h0, d & 8'hf9});
      chk_en(d);
      activate <= 5'h0a;
      chk_en(d);
    end
    $display("test disable done");
  endtask : t_disable
  task automatic t_lock;
    apb(1'b1, 10'h088, 32'h0);
    lock_cfg <= 2'h1;
    lock_pin <= 1'b1;
    apb(1'b1, 10'h088, 32'hf9);
    apb(1'b0, 10'h088, 32'h0);
    chk(rd, 32'h0);
    lock_pin <= 1'b0;
    apb(1'b1, 10'h088, 32'h48);
    apb(1'b0, 10'h088, 32'h0);
    chk(rd, 32'h48);
    lock_cfg <= 2'h2;
    lock_pin <= 1'b1;
    apb(1'b1, 10'h088, 32'h30);
    apb(1'b0, 10'h088, 32'h0);
    chk(rd, 32'h30);
    lock_cfg <= 2'h0;
    pstrb <= 4'he;
    apb(1'b1, 10'h088, 32'h80);
    apb(1'b0, 10'h088, 32'h0);
    chk(rd, 32'h30);
    pstrb <= 4'hf;
    $display("test lock done");
  endtask : t_lock
  task automatic t_protect;
    logic [4:0] i;
    apb(1'b1, 10'h088, 32'h0);
    for (int k = 0; k < 32; k++) begin
      i = k[4:0];
      if (k == 16) apb(1'b1, 10'h088, 32'h01);
      @(posedge pclk);
      {drive_select_zero_n, drive_select_one_n, force_write_protect, write_protect_n} <= i[3:0];
      @(negedge pclk);
      chk({31'h0, core_write_protect},
          {31'h0, i[4] | (~i[3] & i[1]) | (~i[2] & i[1]) | ~i[0]});
    end
    $display("test protect done");
  endtask : t_protect
  task automatic t_midreset;
    apb(1'b1, 10'h088, 32'hf9);
    chk_en(8'hf9);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_en(8'h00);
    chk({31'h0, core_write_protect}, 32'h0);
    apb(1'b0, 10'h088, 32'h0);
    chk(rd, 32'h0);
    $display("test midreset done");
  endtask : t_midreset
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, lock_pin, lock_cfg} = '0;
    pstrb = 4'hf;
    floppy_rate = '0;
    serial_one_fifo = '0;
    serial_two_fifo = '0;
    activate = 5'h15;
    {drive_select_zero_n, drive_select_one_n, write_protect_n, force_write_protect} = 4'he;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_shadow();
    t_disable();
    t_lock();
    t_protect();
    t_midreset();
    close_out();
  end
endmodule : testbench
